// ===== core/spin_sync_consts.vh
// Constants for the spinner rotation synchroniser.
`ifndef SPIN_SYNC_CONSTS_VH
`define SPIN_SYNC_CONSTS_VH
`define ADDR_W             32
`define OFS_ENABLE         32'h640000b0
`define OFS_CAPTURE        32'h640000b4
`define OFS_PRESET         32'h640000b8
`define OFS_TRIG_SEL       32'h640000ac
`define OFS_SYNC_SEL       32'h6400008c
`define ENABLE_BIT         0
`define SEL_LSB            1
`define SYNC_LSB           5
`define CNT_W              16
`define PERIOD_PS          12500
`define RST_VALUE          16'h0000
`endif

// ===== core/spin_sync.v
// Spinner rotation synchroniser with period and revolution counters.
`default_nettype none
`include "spin_sync_consts.vh"
// What this block does
// - Select codes X000..X011 route trigger 1..4 to counter input, no output.
// - Select codes X100..X111 route trigger and drive internal trigger of same index.
// - Select top bit picks revolutions-done pulse (0) or restart pulse (1).
// - Enable register bit 0 enables counters when 1, disables when 0.
// - Reset clears enable bit and both counters.
// - Enable register read returns enable, select and sync bits; upper bits zero.
// - Enabled and before stop, first counter counts every clock, cleared at crossing.
// - At crossing before stop, capture first counter, then clear it.
// - Captured value N means revolution time (N+1) times 12.5 ns.
// - On stop, first counter holds value and capture stops updating.
// - When second counter reaches zero, first counter counts down to zero.
// - First counter at zero with second at zero issues restart pulse.
// - Revolution preset register is writable and readable.
// - Before stop the second counter stays halted.
// - After stop second counter decrements at each crossing from preset.
// - Second counter halts at zero, reloads from preset when first reaches zero.
// - Period capture register is read-only and cleared at reset.
module spin_sync (
  // Clock, reset and enable
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire        CE,
  // Register port
  input  wire [31:0] ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  // Triggers and sequencer
  input  wire [3:0]  EXTERNAL_TRIGGER,
  input  wire        SEQ_STOP,
  output reg  [3:0]  INTERNAL_TRIGGER_OUT,
  output wire        RESTART
);

  // Sequencer states of the counter pair.
  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_DOWN = 2'h2;

  // Software-visible registers.
  reg         enable_q;
  reg         enable_d;
  reg  [3:0]  sel_q;
  reg  [3:0]  sel_d;
  reg  [3:0]  sync_q;
  reg  [3:0]  sync_d;
  reg  [15:0] preset_q;
  reg  [15:0] preset_d;
  reg  [15:0] capture_q;
  reg  [15:0] capture_d;
  reg  [15:0] rdata_d;

  // Counter pair and its pulses.
  reg  [15:0] cnt1_q;
  reg  [15:0] cnt1_d;
  reg  [15:0] cnt2_q;
  reg  [15:0] cnt2_d;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         done_q;
  reg         done_d;
  reg         restart_q;
  reg         restart_d;

  // Decoded strobes.
  wire        wr_enable;
  wire        wr_trig_sel;
  wire        wr_sync_sel;
  wire        wr_preset;
  wire        rd_enable;
  wire        rd_capture;
  wire        rd_preset;

  // Trigger paths and zero detects.
  wire [3:0]  line_sel;
  wire [3:0]  trig_d;
  wire [15:0] enable_word;
  wire        zc;
  wire        pulse;
  wire        cnt1_zero;
  wire        cnt2_zero;

  // Address match, shared by the write and read decoders.
  function hit;
    input [31:0] a;
    input [31:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // One-hot line decode of the low select bits, for the input and output paths.
  function [3:0] onehot4;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: onehot4 = 4'h1;
        2'h1: onehot4 = 4'h2;
        2'h2: onehot4 = 4'h4;
        default: onehot4 = 4'h8;
      endcase
    end
  endfunction

  // Write and read decode.
  assign wr_enable   = WR & hit(ADDR, `OFS_ENABLE);
  assign wr_trig_sel = WR & hit(ADDR, `OFS_TRIG_SEL);
  assign wr_sync_sel = WR & hit(ADDR, `OFS_SYNC_SEL);
  assign wr_preset   = WR & hit(ADDR, `OFS_PRESET);
  assign rd_enable   = RD & hit(ADDR, `OFS_ENABLE);
  assign rd_capture  = RD & hit(ADDR, `OFS_CAPTURE);
  assign rd_preset   = RD & hit(ADDR, `OFS_PRESET);

  assign line_sel = onehot4(sel_q[1:0]);
  // A trigger held high for several clocks counts as several crossings, so the
  // source must deliver a single-clock pulse per revolution.
  assign zc       = |(EXTERNAL_TRIGGER & line_sel);

  assign pulse   = sel_q[3] ? restart_q : done_q;
  assign RESTART = restart_q;

  // Zero detects used by the waiting and backward phases.
  assign cnt1_zero = (cnt1_q == `RST_VALUE);
  assign cnt2_zero = (cnt2_q == `RST_VALUE);

  assign enable_word = {7'h00, sync_q, sel_q, enable_q};

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_trig
      assign trig_d[i] = sel_q[2] & line_sel[i] & pulse;
    end
  endgenerate

  always @* begin
    enable_d = enable_q;
    if (wr_enable) begin
      enable_d = WDATA[`ENABLE_BIT];
    end
  end

  // The select bits stay writable while the counters are disabled.
  always @* begin
    sel_d = sel_q;
    if (wr_trig_sel) begin
      sel_d = WDATA[3:0];
    end
  end

  // The sync bits are only stored for readback.
  always @* begin
    sync_d = sync_q;
    if (wr_sync_sel) begin
      sync_d = WDATA[3:0];
    end
  end

  always @* begin
    preset_d = preset_q;
    if (wr_preset) begin
      preset_d = WDATA;
    end
  end

  always @* begin
    capture_d = capture_q;
    if (enable_q && (state_q == ST_RUN) && !SEQ_STOP && zc) begin
      capture_d = cnt1_q;
    end
  end

  // The stop has priority over a crossing in the same cycle, so the capture
  // register never takes a value cut short by the stop.
  always @* begin
    cnt1_d    = cnt1_q;
    cnt2_d    = cnt2_q;
    state_d   = state_q;
    done_d    = 1'b0;
    restart_d = 1'b0;
    if (!enable_q) begin
      cnt1_d  = `RST_VALUE;
      cnt2_d  = `RST_VALUE;
      state_d = ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          cnt2_d = preset_q;
          if (SEQ_STOP) begin
            state_d = ST_WAIT;
          end else if (zc) begin
            cnt1_d = `RST_VALUE;
          end else begin
            cnt1_d = cnt1_q + 16'h0001;
          end
        end
        ST_WAIT: begin
          if (cnt2_zero) begin
            state_d = ST_DOWN;
            done_d  = 1'b1;
          end else if (zc) begin
            cnt2_d = cnt2_q - 16'h0001;
          end
        end
        ST_DOWN: begin
          if (cnt1_zero) begin
            restart_d = 1'b1;
            cnt2_d  = preset_q;
            state_d = ST_RUN;
          end else begin
            cnt1_d = cnt1_q - 16'h0001;
          end
        end
        default: begin
          state_d = ST_RUN;
        end
      endcase
    end
  end

  // Unmapped and write-only addresses read as zero.
  always @* begin
    rdata_d = 16'h0000;
    if (rd_enable) begin
      rdata_d = enable_word;
    end
    if (rd_capture) begin
      rdata_d = capture_q;
    end
    if (rd_preset) begin
      rdata_d = preset_q;
    end
  end

  always @(posedge CLK) begin
    if (SYS_RST) begin
      enable_q <= 1'b0;
    end else if (CE) begin
      enable_q <= enable_d;
    end
  end

  // Trigger select register.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      sel_q <= 4'h0;
    end else if (CE) begin
      sel_q <= sel_d;
    end
  end

  // Sync select register.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      sync_q <= 4'h0;
    end else if (CE) begin
      sync_q <= sync_d;
    end
  end

  // Revolution preset register.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      preset_q <= `RST_VALUE;
    end else if (CE) begin
      preset_q <= preset_d;
    end
  end

  always @(posedge CLK) begin
    if (SYS_RST) begin
      capture_q <= `RST_VALUE;
    end else if (CE) begin
      capture_q <= capture_d;
    end
  end

  // First counter.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      cnt1_q <= `RST_VALUE;
    end else if (CE) begin
      cnt1_q <= cnt1_d;
    end
  end

  // Second counter.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      cnt2_q <= `RST_VALUE;
    end else if (CE) begin
      cnt2_q <= cnt2_d;
    end
  end

  // Phase of the counter pair.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      state_q <= ST_RUN;
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // Revolutions-done pulse.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      done_q <= 1'b0;
    end else if (CE) begin
      done_q <= done_d;
    end
  end

  // Restart-position pulse.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      restart_q <= 1'b0;
    end else if (CE) begin
      restart_q <= restart_d;
    end
  end

  // The echo lags the chosen pulse by one clock.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      INTERNAL_TRIGGER_OUT <= 4'h0;
    end else if (CE) begin
      INTERNAL_TRIGGER_OUT <= trig_d;
    end
  end

  // Read data is registered so that it stands only in the cycle after the strobe.
  always @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= 16'h0000;
    end else if (CE) begin
      RDATA <= rdata_d;
    end
  end

endmodule // spin_sync
`default_nettype wire

// ===== tb/spin_sync_assertions.sv
// Port checker for the spinner synchroniser.
`default_nettype none
`include "spin_sync_consts.vh"
module spin_sync_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // Register port
  input wire logic        RD,
  input wire logic [31:0] ADDR,
  input wire logic [15:0] RDATA,
  // Sequencer side
  input wire logic        SEQ_STOP,
  input wire logic        RESTART,
  input wire logic [3:0]  INTERNAL_TRIGGER_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  rst_out_a: assert property ($past(SYS_RST) |-> RDATA == 0 && !RESTART) else $error("busy after reset");
  idle_rd_a: assert property (!$past(RD) |-> RDATA == 0) else $error("stray read data");
  unmap_read_a: assert property (RD && !(ADDR inside {`OFS_ENABLE, `OFS_CAPTURE, `OFS_PRESET}) |=> RDATA == 0)
    else $error("unmapped read");
  en_upper_a: assert property (RD && ADDR == `OFS_ENABLE |=> RDATA[15:9] == 0) else $error("upper bits set");
  restart_one_a: assert property (RESTART |=> !RESTART) else $error("long restart");
  stop_hold_a: assert property (SEQ_STOP |=> !RESTART [*2]) else $error("early restart");
  trig_hot_a: assert property ($onehot0(INTERNAL_TRIGGER_OUT)) else $error("two triggers");
  trig_one_a: assert property (INTERNAL_TRIGGER_OUT != 0 |=> INTERNAL_TRIGGER_OUT == 0) else $error("long trigger");
endmodule // spin_sync_chk
bind spin_sync spin_sync_chk spin_sync_chk_inst (.*);
`default_nettype wire

// ===== tb/rotor_seq_model.sv
// Rotor trigger source and sequencer stand-in.
`default_nettype none
module rotor_seq_model #(parameter int P = 40) (
  input wire logic clk, go,
  input wire logic [1:0] tsel,
  output logic [3:0] trig = 4'h0,
  output logic stop = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int c = 0;
  always @(posedge clk) begin
    c <= c == P - 1 ? 0 : c + 1;
    trig <= c == P - 1 ? 4'h1 << tsel : 4'h0;
    stop <= go;
  end
endmodule // rotor_seq_model
`default_nettype wire

// ===== tb/tb_spin_sync.sv
// Bench for the spinner synchroniser.
`default_nettype none
`include "spin_sync_consts.vh"
module tb_spin_sync;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 40;
  logic CLK = 0, SYS_RST = 1, CE = 1, WR = 0, RD = 0, SEQ_STOP, RESTART, go = 0;
  logic [31:0] ADDR = 0;
  logic [15:0] WDATA = 0, RDATA;
  logic [3:0] EXTERNAL_TRIGGER, INTERNAL_TRIGGER_OUT, sel = 0, seen;
  int num_errors = 0, num_checks = 0, n;
  always #50 CLK = ~CLK;
  spin_sync spin_sync_inst (
    .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .EXTERNAL_TRIGGER(EXTERNAL_TRIGGER), .SEQ_STOP(SEQ_STOP), .INTERNAL_TRIGGER_OUT(INTERNAL_TRIGGER_OUT),
    .RESTART(RESTART));
  rotor_seq_model #(.P(P)) rotor_seq_model_inst (.clk(CLK), .go, .tsel(sel[1:0]), .trig(EXTERNAL_TRIGGER),
    .stop(SEQ_STOP));
  task automatic chk(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  // A read compares against d; a write stores d.
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
    @(posedge CLK);
    {WR, RD, ADDR, WDATA} <= {w, !w, a, d};
    @(posedge CLK);
    {WR, RD} <= 2'b00;
    #1 if (!w) chk(RDATA, d);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic regs_run;
    bus(0, `OFS_ENABLE, 16'h0000);
    bus(1, `OFS_CAPTURE, 16'h1234);
    bus(0, `OFS_CAPTURE, 16'h0000);
    bus(0, `OFS_TRIG_SEL, 16'h0000);
    bus(1, `OFS_PRESET, 16'h0002);
    bus(1, `OFS_SYNC_SEL, 16'h000a);
    bus(1, `OFS_ENABLE, 16'h0001);
    bus(0, `OFS_PRESET, 16'h0002);
  endtask
  // While the clock enable is low a write is lost and read data hold their last value.
  task automatic ce_run;
    @(posedge CLK);
    CE <= 1'b0;
    bus(1, `OFS_PRESET, 16'h0007);
    bus(0, `OFS_PRESET, 16'h0000);
    @(posedge CLK);
    CE <= 1'b1;
    bus(0, `OFS_PRESET, 16'h0002);
  endtask
  task automatic stop_run(input logic [3:0] s);
    @(posedge CLK);
    sel <= s;
    bus(1, `OFS_TRIG_SEL, 16'(s));
    bus(0, `OFS_ENABLE, {7'h00, 4'ha, s, 1'b1});
    repeat (2 * P) @(posedge CLK);
    bus(0, `OFS_CAPTURE, 16'(P - 1));
    @(posedge CLK);
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    seen = 4'h0;
    for (n = 0; n < 999 && RESTART !== 1'b1; n++) begin
      @(posedge CLK);
      #1 seen |= INTERNAL_TRIGGER_OUT;
    end
    if (n == 999) begin
      num_errors++;
      results();
    end
    @(posedge CLK);
    #1 chk(16'(INTERNAL_TRIGGER_OUT), s[3:2] == 2'b11 ? 16'h1 << s[1:0] : 16'h0);
    chk(16'(seen | INTERNAL_TRIGGER_OUT), s[2] ? 16'h1 << s[1:0] : 16'h0);
    // Preset two means two revolutions from stop to restart.
    chk(16'((n + P / 2) / P), 16'h0002);
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    regs_run();
    ce_run();
    for (int i = 0; i < 16; i++) stop_run(4'(i));
    results();
  end
endmodule // tb_spin_sync
`default_nettype wire
